/* design/hbs_brake_sequencer.sv */
// Summary of operation
// - After brake engage, wait engage delay (0..3000 ms, default 100) before motor power drops.
// - After motor power on, wait release delay (0..3000 ms, default 0) before motion.
// - During release delay, hold position and mask incoming motion commands.
// - On servo-off, decelerate; engage brake on decel time limit or low speed, first wins.
// - Brake speed threshold programmable 30..3000 RPM, default 30.
// - Brake output changes within 500 ms after servo enable.
// - Brake release output ON only when function selected and timing satisfied.
`timescale 1ns/1ps
module hbs_brake_sequencer
    import hbs_pkg::*;
#(
    parameter int MS_CYCLES = HBS_MS_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        servoEnableCmd,
    input  wire logic [15:0] motorSpeed,
    input  wire logic [15:0] decelTimeLimit,
    input  wire logic        brakeFuncEnable,
    input  wire logic        parWrEn,
    input  wire logic        parRdEn,
    input  wire logic [15:0] parIndex,
    input  wire logic [15:0] parWrData,
    output logic [15:0]      parRdData,
    output logic             motorPowerOn,
    output logic             cmdMask,
    output logic             brakeReleaseSignal,
    output logic [2:0]       seqState
);

    logic [15:0] engageDelay_reg;
    logic [15:0] releaseDelay_reg;
    logic [15:0] speedThresh_reg;
    logic [15:0] parRdData_reg;
    logic        servoSync1_reg;
    logic        servoSync2_reg;
    hbs_state_t  state_reg;
    hbs_state_t  state_next;
    logic        relHeld_reg;
    logic        relHeld_next;
    logic        powerOn_reg;
    logic        cmdMask_reg;
    logic        brakeOut_reg;
    logic        timerClear;
    logic [15:0] elapsedMs;
    logic [15:0] relOutMs;
    logic [15:0] delayClip;
    logic [15:0] speedClip;

    // ------------------------------------------------------------
    // Parameter registers
    // ------------------------------------------------------------
    // Writes are clipped into the legal range instead of refused
    assign delayClip = (parWrData > HBS_DELAY_MAX_MS) ? HBS_DELAY_MAX_MS : parWrData;
    assign speedClip = (parWrData < HBS_SPEED_MIN_RPM) ? HBS_SPEED_MIN_RPM :
                       (parWrData > HBS_SPEED_MAX_RPM) ? HBS_SPEED_MAX_RPM : parWrData;

    // Values are compared live, so a write acts at once, even on a sequence in progress
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            engageDelay_reg  <= HBS_ENGAGE_DELAY_RST;
            releaseDelay_reg <= HBS_RELEASE_DELAY_RST;
            speedThresh_reg  <= HBS_SPEED_THRESH_RST;
        end else if (parWrEn) begin
            unique case (parIndex)
                HBS_IDX_ENGAGE_DELAY:  engageDelay_reg  <= delayClip;
                HBS_IDX_RELEASE_DELAY: releaseDelay_reg <= delayClip;
                HBS_IDX_SPEED_THRESH:  speedThresh_reg  <= speedClip;
                default: ;
            endcase
        end
    end

    // Read data, unmapped indices read as zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            parRdData_reg <= 16'h0;
        end else if (parRdEn) begin
            unique case (parIndex)
                HBS_IDX_ENGAGE_DELAY:  parRdData_reg <= engageDelay_reg;
                HBS_IDX_RELEASE_DELAY: parRdData_reg <= releaseDelay_reg;
                HBS_IDX_SPEED_THRESH:  parRdData_reg <= speedThresh_reg;
                default:               parRdData_reg <= 16'h0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Servo enable pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            servoSync1_reg <= 1'b0;
            servoSync2_reg <= 1'b0;
        end else begin
            servoSync1_reg <= servoEnableCmd;
            servoSync2_reg <= servoSync1_reg;
        end
    end

    // ------------------------------------------------------------
    // Time in current state
    // ------------------------------------------------------------
    assign timerClear = (state_next != state_reg);

    hbs_ms_timer #(
        .MS_CYCLES (MS_CYCLES)
    ) u_timer (
        .mclk      (mclk),
        .reset_n   (reset_n),
        .clear     (timerClear),
        .elapsedMs (elapsedMs)
    );

    // Brake release point inside the release phase is capped for the 500 ms bound
    assign relOutMs = (releaseDelay_reg > HBS_RELEASE_MAX_MS) ? HBS_RELEASE_MAX_MS : releaseDelay_reg;

    // ------------------------------------------------------------
    // Sequencer next state
    // ------------------------------------------------------------
    // A re-enable during shutdown finishes the stop first; idle then restarts
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            HBS_IDLE: begin
                if (servoSync2_reg) begin
                    state_next = HBS_RELEASE;
                end
            end
            HBS_RELEASE: begin
                if (!servoSync2_reg) begin
                    state_next = HBS_DECEL;
                end else if (elapsedMs >= releaseDelay_reg) begin
                    state_next = HBS_RUN;
                end
            end
            HBS_RUN: begin
                if (!servoSync2_reg) begin
                    state_next = HBS_DECEL;
                end
            end
            HBS_DECEL: begin
                if (elapsedMs >= decelTimeLimit || motorSpeed < speedThresh_reg) begin
                    state_next = HBS_ENGAGE;
                end
            end
            HBS_ENGAGE: begin
                if (elapsedMs >= engageDelay_reg) begin
                    state_next = HBS_IDLE;
                end
            end
        endcase
    end

    // Brake release held from its release point until the engage phase
    always_comb begin
        relHeld_next = relHeld_reg;
        if (state_next == HBS_IDLE || state_next == HBS_ENGAGE) begin
            relHeld_next = 1'b0;
        end else if (state_next == HBS_RUN) begin
            relHeld_next = 1'b1;
        end else if (state_reg == HBS_RELEASE && elapsedMs >= relOutMs) begin
            relHeld_next = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State and output registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg   <= HBS_IDLE;
            relHeld_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            relHeld_reg <= relHeld_next;
        end
    end

    // Outputs follow the next state so they line up with state_reg
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            powerOn_reg  <= 1'b0;
            cmdMask_reg  <= 1'b1;
            brakeOut_reg <= 1'b0;
        end else begin
            powerOn_reg  <= (state_next != HBS_IDLE);
            cmdMask_reg  <= (state_next != HBS_RUN);
            brakeOut_reg <= relHeld_next & brakeFuncEnable;
        end
    end

    assign parRdData          = parRdData_reg;
    assign motorPowerOn       = powerOn_reg;
    assign cmdMask            = cmdMask_reg;
    assign brakeReleaseSignal = brakeOut_reg;
    assign seqState           = state_reg;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);

    brake_idle_held_a: assert property (state_reg == HBS_IDLE |-> !brakeReleaseSignal && !motorPowerOn)
        else $error("brake released or power on in idle");
    release_mask_a: assert property (state_reg == HBS_RELEASE |-> cmdMask && motorPowerOn)
        else $error("commands not masked during release delay");
    release_exit_a: assert property (state_reg == HBS_RELEASE && servoSync2_reg && elapsedMs >= releaseDelay_reg
                                     |=> state_reg == HBS_RUN && !cmdMask)
        else $error("release delay exit missed");
    decel_speed_a: assert property (state_reg == HBS_DECEL && motorSpeed < speedThresh_reg
                                    |=> state_reg == HBS_ENGAGE && !brakeReleaseSignal)
        else $error("low speed did not engage brake");
    decel_timeout_a: assert property (state_reg == HBS_DECEL && elapsedMs >= decelTimeLimit
                                      |=> state_reg == HBS_ENGAGE)
        else $error("decel time limit did not engage brake");
    engage_power_a: assert property (state_reg == HBS_ENGAGE && elapsedMs < engageDelay_reg
                                     |-> motorPowerOn ##1 (state_reg != HBS_IDLE || $past(elapsedMs) >= engageDelay_reg))
        else $error("motor power dropped before engage delay");
    release_bound_a: assert property (state_reg == HBS_RELEASE && !relHeld_reg |-> elapsedMs <= HBS_RELEASE_MAX_MS)
        else $error("brake release later than 500 ms bound");
    brake_func_a: assert property (brakeReleaseSignal |-> $past(brakeFuncEnable) && motorPowerOn)
        else $error("brake output on without function enable");
    thresh_write_a: assert property (parWrEn && parIndex == HBS_IDX_SPEED_THRESH
                                     |=> speedThresh_reg >= HBS_SPEED_MIN_RPM && speedThresh_reg <= HBS_SPEED_MAX_RPM)
        else $error("speed threshold out of range");
    delay_write_a: assert property (parWrEn && parIndex == HBS_IDX_ENGAGE_DELAY && parWrData <= HBS_DELAY_MAX_MS
                                    |=> engageDelay_reg == $past(parWrData))
        else $error("engage delay write not taken");

    run_reach_c: cover property (state_reg == HBS_RELEASE ##1 state_reg == HBS_RUN);
    speed_stop_c: cover property (state_reg == HBS_DECEL && motorSpeed < speedThresh_reg && elapsedMs < decelTimeLimit);
    time_stop_c: cover property (state_reg == HBS_DECEL && motorSpeed >= speedThresh_reg && elapsedMs >= decelTimeLimit);
    cycle_done_c: cover property (state_reg == HBS_ENGAGE ##1 state_reg == HBS_IDLE);

endmodule // hbs_brake_sequencer

/* include/hbs_pkg.sv */
package hbs_pkg;

    // ------------------------------------------------------------
    // Parameter indices
    // ------------------------------------------------------------
    localparam logic [15:0] HBS_IDX_ENGAGE_DELAY  = 16'h2437;
    localparam logic [15:0] HBS_IDX_RELEASE_DELAY = 16'h2438;
    localparam logic [15:0] HBS_IDX_SPEED_THRESH  = 16'h2439;

    // ------------------------------------------------------------
    // Reset values and legal ranges
    // ------------------------------------------------------------
    localparam logic [15:0] HBS_ENGAGE_DELAY_RST  = 16'h0064;
    localparam logic [15:0] HBS_RELEASE_DELAY_RST = 16'h0000;
    localparam logic [15:0] HBS_SPEED_THRESH_RST  = 16'h001e;
    localparam logic [15:0] HBS_DELAY_MAX_MS      = 16'h0bb8;
    localparam logic [15:0] HBS_SPEED_MIN_RPM     = 16'h001e;
    localparam logic [15:0] HBS_SPEED_MAX_RPM     = 16'h0bb8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          HBS_CLK_PERIOD_NS     = 20;
    localparam int          HBS_MS_NS             = 1000000;
    localparam int          HBS_MS_CYCLES         = HBS_MS_NS / HBS_CLK_PERIOD_NS;
    // Brake must switch within 500 ms of enable; margin kept for the pin synchroniser
    localparam logic [15:0] HBS_RELEASE_MAX_MS    = 16'h01f2;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        HBS_IDLE,
        HBS_RELEASE,
        HBS_RUN,
        HBS_DECEL,
        HBS_ENGAGE
    } hbs_state_t;

endpackage

/* design/hbs_ms_timer.sv */
`timescale 1ns/1ps
module hbs_ms_timer
    import hbs_pkg::*;
#(
    parameter int MS_CYCLES = HBS_MS_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        clear,
    output logic [15:0]      elapsedMs
);

    logic [31:0] cycleCnt_reg;
    logic [15:0] msCnt_reg;

    // ------------------------------------------------------------
    // Millisecond counter, restarted by clear
    // ------------------------------------------------------------
    // Saturates so a long stay in one state cannot wrap back to zero
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cycleCnt_reg <= 32'h0;
            msCnt_reg    <= 16'h0;
        end else if (clear) begin
            cycleCnt_reg <= 32'h0;
            msCnt_reg    <= 16'h0;
        end else if (cycleCnt_reg == 32'(MS_CYCLES - 1)) begin
            cycleCnt_reg <= 32'h0;
            if (msCnt_reg != 16'hffff) begin
                msCnt_reg <= msCnt_reg + 16'h1;
            end
        end else begin
            cycleCnt_reg <= cycleCnt_reg + 32'h1;
        end
    end

    assign elapsedMs = msCnt_reg;

endmodule // hbs_ms_timer

/* verif/hbs_brake_model.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Holding brake: mechanical lag between coil command and shoe
// ------------------------------------------------------------
module hbs_brake_model #(
    parameter int LAG_CYCLES = 4
) (
    input  wire logic mclk,
    input  wire logic reset_n,
    input  wire logic brakeReleaseSignal,
    output logic      brakeReleased
);
    int lagCnt;
    // Shoe follows the coil only after the lag, so a short glitch never frees the axis
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            lagCnt        <= 0;
            brakeReleased <= 1'b0;
        end else if (brakeReleaseSignal == brakeReleased) begin
            lagCnt <= 0;
        end else if (lagCnt == LAG_CYCLES - 1) begin
            brakeReleased <= brakeReleaseSignal;
            lagCnt        <= 0;
        end else begin
            lagCnt <= lagCnt + 1;
        end
    end
endmodule // hbs_brake_model

/* verif/tb.sv */
`timescale 1ns/1ps
module tb
    import hbs_pkg::*;
;
    localparam int MS = 10;
    logic mclk = 1'b0, reset_n = 1'b0, servoEnableCmd = 1'b0, brakeFuncEnable = 1'b1;
    logic parWrEn = 1'b0, parRdEn = 1'b0, brakeReleased, motorPowerOn, cmdMask, brakeReleaseSignal;
    logic [15:0] motorSpeed = 16'h01f4, decelTimeLimit = 16'h0032, parIndex = 16'h0000;
    logic [15:0] parWrData = 16'h0000, parRdData;
    logic [2:0]  seqState;
    int fail_count = 0, comparisons = 0, cycles = 0, n;

    always #10 mclk = ~mclk;
    hbs_brake_sequencer #(.MS_CYCLES(MS)) DUT (.mclk(mclk), .reset_n(reset_n),
        .servoEnableCmd(servoEnableCmd), .motorSpeed(motorSpeed), .decelTimeLimit(decelTimeLimit),
        .brakeFuncEnable(brakeFuncEnable), .parWrEn(parWrEn), .parRdEn(parRdEn), .parIndex(parIndex),
        .parWrData(parWrData), .parRdData(parRdData), .motorPowerOn(motorPowerOn), .cmdMask(cmdMask),
        .brakeReleaseSignal(brakeReleaseSignal), .seqState(seqState));
    hbs_brake_model BRK (.mclk(mclk), .reset_n(reset_n), .brakeReleaseSignal(brakeReleaseSignal),
        .brakeReleased(brakeReleased));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
        comparisons++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    // Strobe stays low across one edge so back-to-back calls never re-raise it in the same step
    task automatic wr(input logic [15:0] idx, input logic [15:0] d);
        parWrEn = 1'b1; parIndex = idx; parWrData = d;
        tick(1);
        parWrEn = 1'b0;
        tick(1);
    endtask
    task automatic rd(input logic [15:0] idx, output logic [15:0] d);
        parRdEn = 1'b1; parIndex = idx;
        tick(1);
        parRdEn = 1'b0;
        d = parRdData;
        tick(1);
    endtask
    // Bounded wait for a sequencer state; n holds the edges spent
    task automatic wait_st(input logic [2:0] s, input int lim);
        n = 0;
        while (seqState !== s && n < lim) begin
            tick(1);
            n++;
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Hang guard sized well above the longest scenario
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            wrap_up();
        end
    end

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [15:0] d;
        rd(HBS_IDX_ENGAGE_DELAY, d);  check("engageRst", 16'h0064, d);
        rd(HBS_IDX_RELEASE_DELAY, d); check("releaseRst", 16'h0000, d);
        rd(HBS_IDX_SPEED_THRESH, d);  check("threshRst", 16'h001e, d);
        rd(16'h2440, d);              check("unmapped", 16'h0000, d);
        wr(HBS_IDX_SPEED_THRESH, 16'h0005); rd(HBS_IDX_SPEED_THRESH, d); check("threshLo", 16'h001e, d);
        wr(HBS_IDX_SPEED_THRESH, 16'h0bb9); rd(HBS_IDX_SPEED_THRESH, d); check("threshHi", 16'h0bb8, d);
        wr(HBS_IDX_ENGAGE_DELAY, 16'h0fa0); rd(HBS_IDX_ENGAGE_DELAY, d); check("engageHi", 16'h0bb8, d);
        wr(HBS_IDX_ENGAGE_DELAY, 16'h0002); wr(HBS_IDX_SPEED_THRESH, 16'h0064);
        rd(HBS_IDX_ENGAGE_DELAY, d); check("engageWr", 16'h0002, d);
    endtask
    // Zero release delay, speed threshold ends deceleration
    task automatic t_speed_stop;
        servoEnableCmd = 1'b1;
        wait_st(3'h1, 10);
        check("enableLat", 16'd3, 16'(n));
        check("powerOn", 16'h1, motorPowerOn);
        check("maskRel", 16'h1, cmdMask);
        tick(1);
        check("runState", 16'h2, seqState);
        check("maskRun", 16'h0, cmdMask);
        tick(8);
        check("brakeOut", 16'h1, brakeReleaseSignal);
        check("shoeFree", 16'h1, brakeReleased);
        servoEnableCmd = 1'b0;
        wait_st(3'h3, 10);
        tick(3);
        check("stillDecel", 16'h3, seqState);
        motorSpeed = 16'h0014;
        tick(1);
        check("engState", 16'h4, seqState);
        check("brakeOn", 16'h0, brakeReleaseSignal);
        wait_st(3'h0, 60);
        check("engageGap", 16'h1, 16'(n >= 2 * MS - 2 && n <= 2 * MS + 2));
        check("powerOff", 16'h0, motorPowerOn);
    endtask
    // 3 ms release delay, output function off, decel time limit ends deceleration
    task automatic t_time_stop;
        wr(HBS_IDX_RELEASE_DELAY, 16'h0003);
        brakeFuncEnable = 1'b0;
        motorSpeed = 16'h01f4;
        decelTimeLimit = 16'h0002;
        servoEnableCmd = 1'b1;
        wait_st(3'h1, 10);
        wait_st(3'h2, 80);
        check("relDelay", 16'h1, 16'(n >= 3 * MS - 1 && n <= 3 * MS + 2));
        check("noFunc", 16'h0, brakeReleaseSignal);
        servoEnableCmd = 1'b0;
        wait_st(3'h3, 10);
        wait_st(3'h4, 80);
        check("decelLim", 16'h1, 16'(n >= 2 * MS - 1 && n <= 2 * MS + 2));
        wait_st(3'h0, 60);
        check("idleBack", 16'h0, seqState);
        brakeFuncEnable = 1'b1;
    endtask
    // Long release delay: brake still switches inside 500 ms while commands stay masked
    task automatic t_long_release;
        wr(HBS_IDX_RELEASE_DELAY, 16'h0258);
        motorSpeed = 16'h0000;
        servoEnableCmd = 1'b1;
        wait_st(3'h1, 10);
        n = 0;
        while (brakeReleaseSignal !== 1'b1 && n < 520 * MS) begin
            tick(1);
            n++;
        end
        check("within500", 16'h1, 16'((n + 3) < 500 * MS));
        check("maskLong", 16'h1, cmdMask);
        check("stillRel", 16'h1, seqState);
        servoEnableCmd = 1'b0;
        wait_st(3'h4, 20);
        check("abortEng", 16'h0, brakeReleaseSignal);
        wait_st(3'h0, 60);
        check("idleMask", 16'h1, cmdMask);
    endtask

    initial begin
        tick(2);
        reset_n = 1'b1;
        t_regs();
        t_speed_stop();
        t_time_stop();
        t_long_release();
        wrap_up();
    end
endmodule // tb
